// ==== rivx_ext_partner.sv ====
// Purpose: external reset circuit and interrupt source in front of the sequencer
// Assumes: the bench moves press_in and raise_in at falling clock edges
// Notes: the pin is modelled with its pull-up, so it rests high when not pressed
`timescale 1ns/1ps
`default_nettype none
module rivx_ext_partner (
	input wire logic press_in,
	input wire logic raise_in,
	output logic pin_n_out,
	output logic irq_out
);
	// low only while pressed, pull-up holds it high otherwise
	assign pin_n_out = press_in ? 1'b0 : 1'b1;
	assign irq_out = raise_in;
endmodule : rivx_ext_partner
`default_nettype wire

// ==== rivx_pkg.sv ====
// Purpose: shared constants and types for the reset and interrupt sequencer
// Assumes: 11-bit program counter, 8-bit data path
// Notes: none
`default_nettype none
package rivx_pkg;
	localparam int PC_W = 11;
	localparam int DATA_W = 8;
	localparam int STACK_DEPTH = 8;
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [10:0] IRQ_VECTOR = 11'h008;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam int TIMEOUT_BIT = 7;
	localparam int POWERDOWN_BIT = 6;
	localparam logic [7:0] CAUSE_MASK = 8'hc0;
	typedef enum logic [1:0] {
		RIVX_CAUSE_POWERON,
		RIVX_CAUSE_WATCHDOG,
		RIVX_CAUSE_EXTERNAL
	} rivx_cause_t;
	typedef enum {
		RIVX_ST_RESET,
		RIVX_ST_RUN
	} rivx_state_t;
endpackage : rivx_pkg
`default_nettype wire

// ==== rivx_seq.sv ====
// Purpose: reset and interrupt program-flow sequencer of a small 8-bit core
// Assumes: core pulses instr_done_in once per retired instruction
// Notes: the external reset pin passes two flip-flops first
// What this block does
// - any reset fetches from reset vector
// - power-on reset: timeout set, powerdown clear
// - watchdog reset: both cause flags clear
// - external reset: both cause flags set
// - program counter loaded with reset vector
// - all system registers but the shared input bit return to defaults; that bit resets on power-on only
// - interrupt pushes pc, jumps to vector
// - save/restore work and flags, not cause
// - save buffer is one level only
// - reset pin active low, idles high
// - disabled reset pin is plain input bit
// - return stack holds eight levels
`timescale 1ns/1ps
`default_nettype none
module rivx_seq (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ext_reset_pin_n_in,
	input wire logic ext_reset_enable_in,
	input wire logic watchdog_overflow_in,
	input wire logic instr_done_in,
	input wire logic [10:0] next_pc_in,
	input wire logic irq_request_in,
	input wire logic save_in,
	input wire logic restore_in,
	input wire logic return_from_interrupt_in,
	input wire logic [7:0] work_register_in,
	input wire logic [7:0] program_flags_reg_in,
	output logic [10:0] pc_out,
	output logic pc_load_out,
	output logic irq_ack_out,
	output logic core_reset_out,
	output logic timeout_flag_out,
	output logic powerdown_flag_out,
	output logic [7:0] work_register_out,
	output logic [7:0] program_flags_reg_out,
	output logic restore_valid_out,
	output logic shared_reset_input_bit_out
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser; first stage read only by the second
	logic pin_s1_ff;
	logic pin_s2_ff;
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end else begin
			pin_s1_ff <= ext_reset_pin_n_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end
	wire logic ext_reset_req = ext_reset_enable_in && !pin_s2_ff;
	wire logic any_reset = !reset_n_in || watchdog_overflow_in || ext_reset_req;
	// a held watchdog request holds the core in reset, like the pin
	// watchdog wins over pin so the cause matches the source that fired first in practice
	wire rivx_pkg::rivx_cause_t cause =
		!reset_n_in ? rivx_pkg::RIVX_CAUSE_POWERON :
		watchdog_overflow_in ? rivx_pkg::RIVX_CAUSE_WATCHDOG :
		rivx_pkg::RIVX_CAUSE_EXTERNAL;
	////////////////////////////////////////////////////////////////////////////
	// every reset empties the stack so no stale return address survives
	rivx_stack_if st ();
	rivx_stack #(.DEPTH(rivx_pkg::STACK_DEPTH)) u_stack (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.st(st)
	);
	rivx_pkg::rivx_state_t state_ff;
	wire logic running = (state_ff == rivx_pkg::RIVX_ST_RUN);
	wire logic take_irq = running && instr_done_in && irq_request_in;
	// irq beats return on one edge; the core must issue the return again
	wire logic take_ret = running && return_from_interrupt_in && !take_irq
		&& !st.empty;
	assign st.clear = any_reset;
	assign st.push = take_irq && !any_reset;
	assign st.push_data = next_pc_in;
	assign st.pop = take_ret && !any_reset;
	wire logic [7:0] save_flags = program_flags_reg_in & ~rivx_pkg::CAUSE_MASK;
	////////////////////////////////////////////////////////////////////////////
	// a restore on the same edge as a save still returns the older contents
	logic [7:0] save_work_ff;
	logic [7:0] save_flags_ff;
	always_ff @(posedge clk_in) begin
		if (any_reset) begin
			state_ff <= rivx_pkg::RIVX_ST_RESET;
			pc_out <= rivx_pkg::RESET_VECTOR;
			pc_load_out <= 1'b1;
			irq_ack_out <= 1'b0;
			core_reset_out <= 1'b1;
			restore_valid_out <= 1'b0;
			save_work_ff <= rivx_pkg::WORK_RESET;
			save_flags_ff <= rivx_pkg::FLAGS_RESET;
			work_register_out <= rivx_pkg::WORK_RESET;
			program_flags_reg_out <= rivx_pkg::FLAGS_RESET;
		end else begin
			state_ff <= rivx_pkg::RIVX_ST_RUN;
			core_reset_out <= 1'b0;
			irq_ack_out <= take_irq;
			pc_load_out <= take_irq || take_ret;
			if (take_irq)
				pc_out <= rivx_pkg::IRQ_VECTOR;
			else if (take_ret)
				pc_out <= st.top_data;
			if (save_in) begin
				save_work_ff <= work_register_in;
				save_flags_ff <= save_flags;
			end
			restore_valid_out <= restore_in;
			if (restore_in) begin
				work_register_out <= save_work_ff;
				program_flags_reg_out <= save_flags_ff;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// cause flags are written only on a reset and hold their value between resets
	always_ff @(posedge clk_in) begin
		if (any_reset) begin
			case (cause)
				rivx_pkg::RIVX_CAUSE_POWERON: begin
					timeout_flag_out <= 1'b1;
					powerdown_flag_out <= 1'b0;
				end
				rivx_pkg::RIVX_CAUSE_WATCHDOG: begin
					timeout_flag_out <= 1'b0;
					powerdown_flag_out <= 1'b0;
				end
				rivx_pkg::RIVX_CAUSE_EXTERNAL: begin
					timeout_flag_out <= 1'b1;
					powerdown_flag_out <= 1'b1;
				end
				default: begin
					timeout_flag_out <= 1'b1;
					powerdown_flag_out <= 1'b0;
				end
			endcase
		end
	end
	// with the reset function off the pin is a bare input; no pull-up, no wakeup here
	always_ff @(posedge clk_in) begin
		if (!reset_n_in)
			shared_reset_input_bit_out <= 1'b1;
		else
			shared_reset_input_bit_out <= ext_reset_enable_in ? 1'b1 : pin_s2_ff;
	end
	////////////////////////////////////////////////////////////////////////////
	// flow checks on what this block drives
	a_por_flags: assert property (
		@(posedge clk_in) !reset_n_in
		|=> timeout_flag_out && !powerdown_flag_out && pc_out == rivx_pkg::RESET_VECTOR)
		else $error("power-on cause flags wrong");
	a_wdt_flags: assert property (
		@(posedge clk_in) reset_n_in && watchdog_overflow_in
		|=> !timeout_flag_out && !powerdown_flag_out)
		else $error("watchdog cause flags wrong");
	a_ext_flags: assert property (
		@(posedge clk_in) reset_n_in && !watchdog_overflow_in
		&& ext_reset_enable_in && !pin_s2_ff |=> timeout_flag_out && powerdown_flag_out)
		else $error("external cause flags wrong");
	a_reset_vector: assert property (
		@(posedge clk_in) any_reset
		|=> pc_load_out && pc_out == rivx_pkg::RESET_VECTOR && core_reset_out)
		else $error("reset did not load reset vector");
	a_core_release: assert property (
		@(posedge clk_in) !any_reset
		|=> !core_reset_out)
		else $error("core reset held without a source");
	a_stack_clear: assert property (
		@(posedge clk_in) any_reset
		|=> st.empty)
		else $error("stack not emptied by reset");
	a_flags_hold: assert property (
		@(posedge clk_in) !any_reset
		|=> $stable(timeout_flag_out) && $stable(powerdown_flag_out))
		else $error("cause flags changed outside reset");
	a_irq_vector: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		take_irq && !any_reset |=> irq_ack_out && pc_out == rivx_pkg::IRQ_VECTOR)
		else $error("interrupt did not vector");
	a_ack_pulse: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		irq_ack_out && !take_irq |=> !irq_ack_out)
		else $error("interrupt ack stood too long");
	a_irq_boundary: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		irq_ack_out |-> $past(instr_done_in))
		else $error("interrupt taken off boundary");
	a_irq_refused: assert property (
		@(posedge clk_in) !running
		|=> !irq_ack_out)
		else $error("interrupt taken before run");
	a_push_data: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		st.push |=> st.top_data == $past(next_pc_in))
		else $error("stack did not keep next pc");
	a_full_hold: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		st.full && st.push |=> st.full)
		else $error("full stack lost its count");
	a_ret_resume: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		take_irq && !any_reset ##1 (take_ret && !any_reset && !take_irq)
		|=> pc_out == $past(next_pc_in, 2))
		else $error("return did not resume saved pc");
	a_ret_empty: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		return_from_interrupt_in && st.empty && !take_irq && !any_reset
		|=> !pc_load_out)
		else $error("return from empty stack loaded pc");
	a_save_restore: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		save_in && !any_reset ##1 (restore_in && !save_in && !any_reset)
		|=> work_register_out == $past(work_register_in, 2)
		&& program_flags_reg_out == ($past(program_flags_reg_in, 2) & ~rivx_pkg::CAUSE_MASK))
		else $error("save buffer restore wrong");
	a_save_overwrite: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		save_in && !any_reset ##1 save_in && !any_reset
		##1 (restore_in && !save_in && !any_reset)
		|=> work_register_out == $past(work_register_in, 2))
		else $error("second save did not overwrite");
	a_restore_pulse: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		restore_in && !any_reset |=> restore_valid_out)
		else $error("restore not flagged");
	a_pin_input: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		!ext_reset_enable_in ##1 !ext_reset_enable_in
		|-> shared_reset_input_bit_out == $past(pin_s2_ff))
		else $error("shared input bit wrong");
	a_pin_disabled: assert property (
		@(posedge clk_in) reset_n_in && !watchdog_overflow_in && !ext_reset_enable_in
		|=> !core_reset_out)
		else $error("disabled pin caused a reset");
	c_irq: cover property (@(posedge clk_in) irq_ack_out);
	c_ret: cover property (@(posedge clk_in) take_ret);
	c_wdt: cover property (@(posedge clk_in) reset_n_in && watchdog_overflow_in);
	c_ext: cover property (@(posedge clk_in) reset_n_in && ext_reset_req);
	c_stack_full: cover property (@(posedge clk_in) st.full && st.push);
endmodule : rivx_seq
`default_nettype wire

// ==== rivx_seq_tb.sv ====
// Purpose: self-checking bench for the reset and interrupt sequencer
// Assumes: inputs change at the falling edge, outputs read there
// Notes: pin resets wait past the two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module rivx_seq_tb;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic press = 1'b0, raise = 1'b0, en = 1'b1, wdog = 1'b0;
	logic done = 1'b0, sv = 1'b0, rs = 1'b0, ret = 1'b0;
	logic [10:0] npc = 11'h000;
	logic [7:0] wr = 8'h00, fr = 8'h00;
	wire logic pin_n, irq;
	logic [10:0] pc;
	logic pc_load, ack, crst, t_f, p_f, rv, pbit;
	logic [7:0] wo, fo;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [10:0] pcs [$];
	always #2.5 clk_in = ~clk_in;
	rivx_ext_partner ext (.press_in(press), .raise_in(raise), .pin_n_out(pin_n), .irq_out(irq));
	rivx_seq uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ext_reset_pin_n_in(pin_n),
		.ext_reset_enable_in(en), .watchdog_overflow_in(wdog), .instr_done_in(done),
		.next_pc_in(npc), .irq_request_in(irq), .save_in(sv), .restore_in(rs),
		.return_from_interrupt_in(ret), .work_register_in(wr), .program_flags_reg_in(fr),
		.pc_out(pc), .pc_load_out(pc_load), .irq_ack_out(ack), .core_reset_out(crst),
		.timeout_flag_out(t_f), .powerdown_flag_out(p_f), .work_register_out(wo),
		.program_flags_reg_out(fo), .restore_valid_out(rv), .shared_reset_input_bit_out(pbit));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic final_report();
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// cause bits never travel through the save buffer
	function automatic logic [7:0] kept(input logic [7:0] f);
		return f & ~rivx_pkg::CAUSE_MASK;
	endfunction : kept
	task automatic cause(input logic t, input logic p);
		chk("pc_out", rivx_pkg::RESET_VECTOR, pc);
		chk("timeout_flag", 11'(t), 11'(t_f));
		chk("powerdown_flag", 11'(p), 11'(p_f));
		chk("work_register", 11'h000, 11'(wo));
	endtask : cause
	// hang guard, the run needs well under a thousand cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			$display("[FAIL] run_cycles expected below %0d seen %0d", 3000, cycles);
			final_report();
		end
	end
	initial begin
		void'($urandom(95848));
		repeat (3) @(negedge clk_in);
		chk("pc_load", 11'h001, 11'(pc_load));
		chk("core_reset", 11'h001, 11'(crst));
		reset_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		cause(1'b1, 1'b0);
		raise = 1'b1;
		@(negedge clk_in);
		chk("irq_ack", 11'h000, 11'(ack));
		done = 1'b1;
		// nine back-to-back entries, one more than the stack holds
		for (int i = 0; i < 9; i++) begin
			npc = 11'($urandom);
			pcs.push_back(npc);
			@(negedge clk_in);
			chk("irq_ack", 11'h001, 11'(ack));
			chk("pc_out", rivx_pkg::IRQ_VECTOR, pc);
		end
		done = 1'b0;
		raise = 1'b0;
		ret = 1'b1;
		for (int i = 8; i > 0; i--) begin
			@(negedge clk_in);
			chk("pc_load", 11'h001, 11'(pc_load));
			chk("pc_out", pcs[i], pc);
		end
		@(negedge clk_in);
		chk("pc_load", 11'h000, 11'(pc_load));
		ret = 1'b0;
		wr = 8'($urandom);
		sv = 1'b1;
		@(negedge clk_in);
		// second save must win; cause bits set so their masking shows
		wr = ~wr;
		fr = 8'($urandom) | rivx_pkg::CAUSE_MASK;
		@(negedge clk_in);
		sv = 1'b0;
		rs = 1'b1;
		@(negedge clk_in);
		rs = 1'b0;
		chk("restore_valid", 11'h001, 11'(rv));
		chk("work_register", 11'(wr), 11'(wo));
		chk("program_flags", 11'(kept(fr)), 11'(fo));
		done = 1'b1;
		raise = 1'b1;
		@(negedge clk_in);
		chk("irq_ack", 11'h001, 11'(ack));
		chk("pc_out", rivx_pkg::IRQ_VECTOR, pc);
		done = 1'b0;
		raise = 1'b0;
		wdog = 1'b1;
		@(negedge clk_in);
		wdog = 1'b0;
		repeat (3) @(negedge clk_in);
		cause(1'b0, 1'b0);
		ret = 1'b1;
		@(negedge clk_in);
		ret = 1'b0;
		chk("pc_load", 11'h000, 11'(pc_load));
		press = 1'b1;
		repeat (4) @(negedge clk_in);
		chk("core_reset", 11'h001, 11'(crst));
		press = 1'b0;
		repeat (5) @(negedge clk_in);
		cause(1'b1, 1'b1);
		en = 1'b0;
		press = 1'b1;
		repeat (4) @(negedge clk_in);
		chk("core_reset", 11'h000, 11'(crst));
		chk("input_bit", 11'h000, 11'(pbit));
		press = 1'b0;
		repeat (4) @(negedge clk_in);
		chk("input_bit", 11'h001, 11'(pbit));
		final_report();
	end
endmodule : rivx_seq_tb
`default_nettype wire

// ==== rivx_stack.sv ====
// Purpose: return-address stack for interrupt entry
// Assumes: push and pop never in the same cycle
// Notes: a push when full drops the oldest entry (wraps)
`timescale 1ns/1ps
`default_nettype none
module rivx_stack #(
	parameter int DEPTH = rivx_pkg::STACK_DEPTH
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	rivx_stack_if.stk st
);
	localparam int PW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("stack depth must be a power of two");
	end
	logic [10:0] mem [DEPTH];
	logic [PW-1:0] ptr_ff;
	logic [PW:0] cnt_ff;
	wire logic [PW-1:0] top_idx = ptr_ff - 1'b1;
	assign st.top_data = mem[top_idx];
	assign st.empty = (cnt_ff == '0);
	assign st.full = (cnt_ff == (PW+1)'(DEPTH));
	always_ff @(posedge clk_in) begin
		if (st.push)
			mem[ptr_ff] <= st.push_data;
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || st.clear) begin
			ptr_ff <= '0;
			cnt_ff <= '0;
		end else if (st.push) begin
			ptr_ff <= ptr_ff + 1'b1;
			cnt_ff <= st.full ? cnt_ff : cnt_ff + 1'b1;
		end else if (st.pop && !st.empty) begin
			ptr_ff <= top_idx;
			cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule : rivx_stack
`default_nettype wire

// ==== rivx_stack_if.sv ====
// Purpose: carrier between the sequencer and its return-address stack
// Assumes: one clock
// Notes: push acts on every cycle it is high, pop on every such cycle the stack is not empty; either may stay high for many cycles
`timescale 1ns/1ps
`default_nettype none
interface rivx_stack_if;
	logic push;
	logic pop;
	logic clear;
	logic [10:0] push_data;
	logic [10:0] top_data;
	logic empty;
	logic full;
	modport seq (output push, output pop, output clear, output push_data,
		input top_data, input empty, input full);
	modport stk (input push, input pop, input clear, input push_data,
		output top_data, output empty, output full);
endinterface : rivx_stack_if
`default_nettype wire
